// ===== design/dec_exec_pkg.sv
// Constants shared by the decrement execution block and its datapath.
// Assumes a 40 MHz core clock, with one clock edge for each instruction phase.
package dec_exec_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] BANK_OFF = 8'h04;
  localparam logic [7:0] WREG_OFF = 8'h08;
  localparam logic [7:0] FLAGS_OFF = 8'h0c;
  localparam logic [7:0] INDEX_OFF = 8'h10;
  localparam logic [7:0] STATE_OFF = 8'h14;
  // Values after reset
  localparam logic CTRL_RST = 1'b0;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [11:0] INDEX_RST = 12'h000;
  // Flag bit positions in the flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  // Opcode patterns on instr[15:10]
  localparam logic [5:0] DECREMENT_BYTE_OP_PAT = 6'h01;
  localparam logic [5:0] DECREMENT_SKIP_ON_ZERO_OP_PAT = 6'h0b;
  // File addresses up to this value sit in the low access bank
  localparam logic [7:0] ACCESS_LOW_MAX = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  // Discarded-cycle counts after a skip
  localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h2;
  localparam logic [7:0] DEC_ONE = 8'h01;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_e;
endpackage

// ===== design/dec_alu.sv
// Eight-bit decrement datapath with its arithmetic flags.
// Purely combinational; the caller registers result and flags.
`timescale 1ns/100ps
`default_nettype none
module dec_alu (
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic carry,
  output logic digit_carry_flag,
  output logic zero,
  output logic overflow_flag,
  output logic negative
);
  // Modulo-256 wrap, 00h becomes ffh
  assign result = operand - dec_exec_pkg::DEC_ONE;
  // Carry and digit carry read as "no borrow"
  assign carry = (operand != 8'h00);
  assign digit_carry_flag = (operand[3:0] != 4'h0);
  assign zero = (result == 8'h00);
  // Only 80h minus one crosses the signed range
  assign overflow_flag = (operand == 8'h80);
  assign negative = result[7];
endmodule
`default_nettype wire

// ===== design/decrement_instruction_exec.sv
// Execution of the two byte decrement instructions over four clock phases.
// Assumes a fetch unit and a data memory on the same clock; APB for registers.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Opcode 000001da with 8-bit file address is the plain decrement.
// - Opcode 001011da with 8-bit file address is decrement-skip-on-zero.
// - Both compute the addressed byte minus one.
// - Destination bit 0 writes working register, 1 writes the byte back.
// - Access bit 0 uses access bank, 1 uses bank pointer register.
// - Access bit 0, extended set on, address up to 5fh: indexed offset mode.
// - Plain decrement updates five flags; skip variant leaves flags alone.
// - Zero result in skip variant discards next instruction, runs a nop cycle.
// - Phases run decode, read, process, write; one cycle per instruction.
// - Skipping a two-word instruction costs two nop cycles, three in all.
module decrement_instruction_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] instr_word,
  input wire logic next_two_word,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic discard_fetch,
  output logic [3:0] phase
);
  dec_exec_pkg::phase_e state_r, state_nxt;
  logic ext_set_r;
  logic [3:0] bank_pointer_register_r;
  logic [7:0] wreg_r;
  logic [4:0] flags_r;
  logic [11:0] index_base_r;
  logic [15:0] instr_r;
  logic active_r;
  logic [1:0] nop_left_r;
  logic [7:0] operand_r;
  logic [7:0] result_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [11:0] mem_addr_r;
  logic mem_rd_r;
  logic mem_wr_r;
  logic [7:0] mem_wdata_r;
  logic discard_r;

  // Decode of the latched instruction
  wire logic is_dec = (instr_r[15:10] == dec_exec_pkg::DECREMENT_BYTE_OP_PAT);
  wire logic is_skip = (instr_r[15:10] == dec_exec_pkg::DECREMENT_SKIP_ON_ZERO_OP_PAT);
  wire logic to_file = instr_r[9];
  wire logic banked = instr_r[8];
  wire logic [7:0] file_addr = instr_r[7:0];
  wire logic low_access = (file_addr <= dec_exec_pkg::ACCESS_LOW_MAX);
  wire logic indexed = !banked && ext_set_r && low_access;
  wire logic [11:0] indexed_addr = index_base_r + {4'h0, file_addr};
  wire logic [3:0] access_bank =
    low_access ? dec_exec_pkg::ACCESS_LOW_BANK : dec_exec_pkg::ACCESS_HIGH_BANK;
  // Bank pointer only matters for banked access
  wire logic [11:0] eff_addr =
    indexed ? indexed_addr :
    banked ? {bank_pointer_register_r, file_addr} : {access_bank, file_addr};
  wire logic run_dec = active_r && (is_dec || is_skip);
  // One strobe per phase of the instruction cycle
  wire logic in_q1 = (state_r == dec_exec_pkg::PH_Q1);
  wire logic in_q2 = (state_r == dec_exec_pkg::PH_Q2);
  wire logic in_q3 = (state_r == dec_exec_pkg::PH_Q3);
  wire logic in_q4 = (state_r == dec_exec_pkg::PH_Q4);
  // Read request straight from the fetched word, so the read lands in Q2
  wire logic fetch_dec = (instr_word[15:10] == dec_exec_pkg::DECREMENT_BYTE_OP_PAT)
    || (instr_word[15:10] == dec_exec_pkg::DECREMENT_SKIP_ON_ZERO_OP_PAT);
  wire logic rd_start = in_q1 && (nop_left_r == 2'h0) && fetch_dec;

  // Datapath
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_ov;
  logic alu_n;
  dec_alu u_alu (
    .operand(operand_r),
    .result(alu_res),
    .carry(alu_c),
    .digit_carry_flag(alu_dc),
    .zero(alu_z),
    .overflow_flag(alu_ov),
    .negative(alu_n)
  );
  wire logic [4:0] alu_flag_vec;
  assign alu_flag_vec[dec_exec_pkg::FLAG_C] = alu_c;
  assign alu_flag_vec[dec_exec_pkg::FLAG_DC] = alu_dc;
  assign alu_flag_vec[dec_exec_pkg::FLAG_Z] = alu_z;
  assign alu_flag_vec[dec_exec_pkg::FLAG_OV] = alu_ov;
  assign alu_flag_vec[dec_exec_pkg::FLAG_N] = alu_n;

  // APB decode
  wire logic apb_access = psel && penable;
  wire logic apb_done = apb_access && pready_r;
  wire logic apb_wr = apb_done && pwrite;
  wire logic hit_ctrl = (paddr == dec_exec_pkg::CTRL_OFF);
  wire logic hit_bank = (paddr == dec_exec_pkg::BANK_OFF);
  wire logic hit_wreg = (paddr == dec_exec_pkg::WREG_OFF);
  wire logic hit_flags = (paddr == dec_exec_pkg::FLAGS_OFF);
  wire logic hit_index = (paddr == dec_exec_pkg::INDEX_OFF);
  wire logic hit_state = (paddr == dec_exec_pkg::STATE_OFF);
  wire logic hit_any = hit_ctrl || hit_bank || hit_wreg || hit_flags || hit_index
    || hit_state;
  // State register is read-only; a write to it is an error too
  wire logic bad_access = !hit_any || (pwrite && hit_state);
  wire logic [31:0] state_word = {12'h000, result_r, 4'h0, active_r, nop_left_r,
    discard_r, state_r};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {31'h0, ext_set_r} :
    hit_bank ? {28'h0, bank_pointer_register_r} :
    hit_wreg ? {24'h0, wreg_r} :
    hit_flags ? {27'h0, flags_r} :
    hit_index ? {20'h0, index_base_r} :
    hit_state ? state_word : 32'h0;

  // Hardware writes to W and flags land in Q4 and beat a software write
  wire logic hw_wreg = in_q4 && run_dec && !to_file;
  wire logic hw_flags = in_q4 && active_r && is_dec;
  // Zero test on the live ALU output; result_r still holds the last result here
  wire logic skip_now = in_q4 && active_r && is_skip && alu_z;
  wire logic [1:0] skip_len =
    next_two_word ? dec_exec_pkg::SKIP_TWO_WORD : dec_exec_pkg::SKIP_ONE_WORD;

  // Phase sequencer
  always_comb begin
    case (state_r)
      dec_exec_pkg::PH_Q1: state_nxt = dec_exec_pkg::PH_Q2;
      dec_exec_pkg::PH_Q2: state_nxt = dec_exec_pkg::PH_Q3;
      dec_exec_pkg::PH_Q3: state_nxt = dec_exec_pkg::PH_Q4;
      dec_exec_pkg::PH_Q4: state_nxt = dec_exec_pkg::PH_Q1;
      default: state_nxt = dec_exec_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= dec_exec_pkg::PH_Q1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Q1 decode: latch the word in every Q1; a discarded slot is latched with active_r low
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_r <= 16'h0000;
      active_r <= 1'b0;
    end else if (in_q1) begin
      instr_r <= instr_word;
      active_r <= (nop_left_r == 2'h0);
    end
  end

  // Discarded cycles do no read, write or register update; only mem_addr still reloads in Q2
  always_ff @(posedge clk) begin
    if (reset) begin
      nop_left_r <= 2'h0;
    end else if (skip_now) begin
      nop_left_r <= skip_len;
    end else if (in_q1 && (nop_left_r != 2'h0)) begin
      nop_left_r <= nop_left_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= skip_now;
    end
  end

  // Read strobe in Q2; the address follows at the end of Q2
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_rd_r <= 1'b0;
    end else begin
      mem_rd_r <= rd_start;
    end
  end

  // Address is refreshed every Q2, even for words that are not decrements
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr_r <= 12'h000;
    end else if (in_q2) begin
      mem_addr_r <= eff_addr;
    end
  end

  // Memory answers in Q3 for the address set at the end of Q2
  always_ff @(posedge clk) begin
    if (reset) begin
      operand_r <= 8'h00;
    end else if (in_q3 && run_dec) begin
      operand_r <= mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_r <= 8'h00;
    end else if (in_q4 && run_dec) begin
      result_r <= alu_res;
    end
  end

  // Write-back of the destination byte
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_wr_r <= 1'b0;
    end else begin
      mem_wr_r <= in_q4 && run_dec && to_file;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_wdata_r <= 8'h00;
    end else if (in_q4 && run_dec) begin
      mem_wdata_r <= alu_res;
    end
  end

  // Software-visible registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_set_r <= dec_exec_pkg::CTRL_RST;
      bank_pointer_register_r <= dec_exec_pkg::BANK_RST;
      index_base_r <= dec_exec_pkg::INDEX_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ext_set_r <= pwdata[0];
      end
      if (hit_bank) begin
        bank_pointer_register_r <= pwdata[3:0];
      end
      if (hit_index) begin
        index_base_r <= pwdata[11:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wreg_r <= dec_exec_pkg::WREG_RST;
    end else if (hw_wreg) begin
      wreg_r <= alu_res;
    end else if (apb_wr && hit_wreg) begin
      wreg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= dec_exec_pkg::FLAGS_RST;
    end else if (hw_flags) begin
      flags_r <= alu_flag_vec;
    end else if (apb_wr && hit_flags) begin
      flags_r <= pwdata[4:0];
    end
  end

  // One wait state keeps every APB output registered
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_access && !pready_r;
      if (apb_access && !pready_r) begin
        prdata_r <= pwrite ? 32'h0 : rd_mux;
        pslverr_r <= bad_access;
      end else begin
        prdata_r <= 32'h0;
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_addr = mem_addr_r;
  assign mem_rd = mem_rd_r;
  assign mem_wr = mem_wr_r;
  assign mem_wdata = mem_wdata_r;
  assign discard_fetch = discard_r;
  assign phase = state_r;
endmodule
`default_nettype wire

// ===== tb/dec_exec_props.sv
// Port checker for the decrement execution block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dec_exec_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic discard_fetch,
  input wire logic [3:0] phase
);
  logic [3:0] phase_r;
  logic reset_r;
  always_ff @(posedge clk) begin
    phase_r <= phase;
    reset_r <= reset;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_PHASE_ROT: assert property (!reset_r |-> phase == {phase_r[2:0], phase_r[3]})
    else $error("phase order broken");
  AST_RD_Q2: assert property (mem_rd |-> phase == 4'h2)
    else $error("read outside second phase");
  AST_WR_AFTER_RD: assert property (mem_wr |-> phase == 4'h1 && $past(mem_rd, 3))
    else $error("write not three cycles after read");
  AST_WDATA: assert property (mem_wr |-> mem_wdata == $past(mem_rdata, 2) - 8'h01)
    else $error("written byte is not operand minus one");
  AST_DISC_Q1: assert property (discard_fetch |-> phase == 4'h1 && $past(mem_rd, 3))
    else $error("discard at wrong moment");
  AST_DISC_ZERO: assert property (discard_fetch |-> $past(mem_rdata, 2) == 8'h01)
    else $error("discard without zero result");
  AST_DISC_NOP: assert property (discard_fetch |=> !mem_rd [*3])
    else $error("discarded cycle did work");
  AST_PREADY: assert property (pready |-> psel && penable && $past(penable) ##1 !pready)
    else $error("ready not one cycle after access start");
endmodule
bind decrement_instruction_exec dec_exec_props dec_exec_props_u (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pready(pready), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .discard_fetch(discard_fetch), .phase(phase));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the decrement execution block.
// Assumes one-wait-state APB answers and freely rotating phases.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, reset, psel, penable, pwrite, next_two_word, pready, pslverr;
  logic mem_rd, mem_wr, discard_fetch, e;
  logic [7:0] paddr, mem_rdata, mem_wdata;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] instr_word;
  logic [11:0] mem_addr;
  logic [3:0] phase;
  int n_errors, n_compared, cyc;
  decrement_instruction_exec dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_word(instr_word), .next_two_word(next_two_word),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .discard_fetch(discard_fetch), .phase(phase));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded run, a hang still ends in the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp);
    cmp({31'h0, e}, 32'h0);
  endtask
  // Expect {read, addr, write, wdata, discard}; wdata masked when no write
  task automatic exec(input logic [15:0] iw, nxt, input logic [7:0] v, input logic ntw,
    input logic [22:0] ex);
    logic [22:0] g;
    do @(posedge clk); while (phase !== 4'h8);
    instr_word <= iw;
    mem_rdata <= v;
    next_two_word <= ntw;
    g = '0;
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk);
      if (i == 4) instr_word <= nxt;
      #1;
      if (i == 1) g[22] = mem_rd;
      if (i == 2) g[21:10] = mem_addr;
      if (i == 4) g[9:0] = {mem_wr, mem_wr ? mem_wdata : 8'h00, discard_fetch};
    end
    cmp(32'(g), 32'(ex));
  endtask
  // Counts reads; clears the word at the last edge so it runs once only
  task automatic rd_count(input int n, input int ex);
    int k;
    k = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      if (i == n) instr_word <= 16'h0000;
      #1;
      if (mem_rd === 1'b1) k++;
    end
    cmp(k, ex);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++) rdchk(8'(i * 4), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    cmp(q, 32'h0);
    cmp({31'h0, e}, 32'h1);
    apb(1'b1, 8'h14, 32'hffff);
    cmp({31'h0, e}, 32'h1);
    apb(1'b1, 8'h04, 32'h3);
    rdchk(8'h04, 32'h3);
  endtask
  task automatic t_plain;
    exec({6'h01, 2'b11, 8'h20}, 0, 8'h00, 0, {1'b1, 12'h320, 1'b1, 8'hff, 1'b0});
    rdchk(8'h0c, 32'h10);
    apb(1'b1, 8'h08, 32'h5a);
    exec({6'h01, 2'b00, 8'h10}, 0, 8'h01, 0, {1'b1, 12'h010, 10'h0});
    rdchk(8'h08, 32'h0);
    rdchk(8'h0c, 32'h07);
    exec({6'h01, 2'b10, 8'h80}, 0, 8'h80, 0, {1'b1, 12'hf80, 1'b1, 8'h7f, 1'b0});
    rdchk(8'h0c, 32'h09);
  endtask
  // A second skip as the next word keeps the flags untouched
  task automatic t_skip(input logic ntw);
    exec({6'h0b, 2'b11, 8'h30}, {6'h0b, 2'b11, 8'h30}, 8'h01, ntw,
      {1'b1, 12'h330, 1'b1, 8'h00, 1'b1});
    rd_count(8 + 4 * ntw, 1);
    rd_count(4 + 4 * ntw, 0);
    rdchk(8'h0c, 32'h09);
  endtask
  task automatic t_nozero;
    exec({6'h0b, 2'b01, 8'h30}, 0, 8'h05, 0, {1'b1, 12'h330, 10'h0});
    rdchk(8'h08, 32'h04);
  endtask
  task automatic t_index;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h10, 32'h123);
    exec({6'h01, 2'b10, 8'h5f}, 0, 8'h10, 0, {1'b1, 12'h182, 1'b1, 8'h0f, 1'b0});
    exec({6'h01, 2'b10, 8'h60}, 0, 8'h10, 0, {1'b1, 12'hf60, 1'b1, 8'h0f, 1'b0});
  endtask
  task automatic t_illegal;
    exec({6'h13, 2'b11, 8'h30}, 0, 8'h01, 0, {1'b0, 12'h330, 10'h0});
    exec({6'h00, 2'b11, 8'h30}, 0, 8'h01, 0, {1'b0, 12'h330, 10'h0});
  endtask
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_word = 16'h0000;
    next_two_word = 1'b0;
    mem_rdata = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_plain();
    t_skip(1'b0);
    t_skip(1'b1);
    t_nozero();
    t_illegal();
    t_index();
    report_and_stop();
  end
endmodule
`default_nettype wire
